// File: core/pcie_root_error_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - With PME interrupt enable set, a PME message that sets PME status raises the interrupt.
// - Setting PME interrupt enable while PME status is already set also raises it.
// - Control bit 2 lets fatal messages or fatal detected errors raise system error.
// - Control bit 1 lets non-fatal messages or detected errors raise system error.
// - Control bit 0 lets correctable messages or detected errors raise system error.
// - System error enables act only in root complex mode.
// - Control bits 15:4 read zero and the four enables reset to zero.
// - Status bits set on detection, clear on write of one, ignore zero writes.
// - Status and mask registers keep their values over reset, cleared only at power-up.
// - A masked error still sets its status bit but enables no header log, moves no first pointer and sends no message.
// - Mask bits 20, 19, 18 mask unsupported request, end-to-end CRC, malformed packet.
// - Mask bits 17, 16, 15 mask receiver overflow, unexpected and aborted completion.
// - Mask bits 14, 13, 12 mask completion timeout, flow control protocol, poisoned packet.
// - Mask bits 4 and 0 mask data link protocol and training errors, all default zero.
// - Slot control and slot status are plain read/write storage.
// - Severity bit set means fatal, clear means non-fatal, choosing the enable used.
module pcie_root_error_control (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      por,
  input  wire logic                      root_mode,
  input  wire root_err_pkg::reg_req_t    reg_req,
  output logic      [31:0]               reg_rdata,
  output logic                           reg_rvalid,
  input  wire root_err_pkg::link_msg_t   link_msg,
  input  wire logic                      cor_detected,
  input  wire logic [31:0]               unc_detected,
  output logic                           system_error_interrupt,
  output logic                           pme_interrupt,
  output logic                           pme_status,
  output logic                           err_msg_fatal,
  output logic                           err_msg_nonfatal,
  output logic                           header_log_en,
  output logic [4:0]                     first_error_ptr,
  output logic                           first_error_valid
);
  // ==========================================
  // Pin synchroniser for root_mode
  logic [1:0] root_mode_sync;
  logic       root_mode_s;
  always_ff @(posedge sys_clk) begin
    root_mode_sync <= {root_mode_sync[0], root_mode};
  end
  assign root_mode_s = root_mode_sync[1];

  // ==========================================
  // Register state
  logic [15:0] root_control_reg;
  logic [31:0] uncorr_error_mask_reg;
  logic [31:0] uncorr_error_severity_reg;
  logic [31:0] uncorr_error_status_reg;
  logic [15:0] slot_control_reg;
  logic [15:0] slot_status_reg;
  logic [31:0] unmasked;
  logic        wr_status;

  function automatic logic hit(input logic [11:0] off);
    hit = reg_req.wr && (reg_req.addr == off);
  endfunction : hit

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      root_control_reg <= root_err_pkg::RC_RESET;
    end else if (hit(root_err_pkg::OFF_ROOT_CONTROL)) begin
      root_control_reg <= reg_req.wdata[15:0] & root_err_pkg::RC_WRITABLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (por) begin
      uncorr_error_mask_reg     <= root_err_pkg::UNC_RESET;
      uncorr_error_severity_reg <= root_err_pkg::UNC_RESET;
    end else begin
      if (hit(root_err_pkg::OFF_UNC_MASK)) begin
        uncorr_error_mask_reg <= reg_req.wdata;
      end
      if (hit(root_err_pkg::OFF_UNC_SEVERITY)) begin
        uncorr_error_severity_reg <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slot_control_reg <= root_err_pkg::SLOT_RESET;
      slot_status_reg  <= root_err_pkg::SLOT_RESET;
    end else if (hit(root_err_pkg::OFF_SLOT_CONTROL)) begin
      slot_control_reg <= reg_req.wdata[15:0];
      slot_status_reg  <= reg_req.wdata[31:16];
    end
  end

  // ==========================================
  // Uncorrectable status bank
  assign wr_status = hit(root_err_pkg::OFF_UNC_STATUS);

  sticky_w1c_bank #(
    .WIDTH (32)
  ) u_status (
    .sys_clk  (sys_clk),
    .por      (por),
    .set_bits (unc_detected & root_err_pkg::UNC_DEFINED),
    .wr_en    (wr_status),
    .wr_data  (reg_req.wdata),
    .q        (uncorr_error_status_reg)
  );

  assign unmasked = unc_detected & root_err_pkg::UNC_DEFINED & ~uncorr_error_mask_reg;

  // ==========================================
  // First error pointer and reporting
  function automatic logic [4:0] lowest(input logic [31:0] v);
    lowest = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 5'(i);
      end
    end
  endfunction : lowest

  logic unm_fatal;
  logic unm_nonfatal;
  assign unm_fatal    = |(unmasked & uncorr_error_severity_reg);
  assign unm_nonfatal = |(unmasked & ~uncorr_error_severity_reg);

  always_ff @(posedge sys_clk) begin
    if (por) begin
      first_error_ptr   <= 5'h00;
      first_error_valid <= 1'b0;
    end else if (!first_error_valid && (|unmasked)) begin
      first_error_ptr   <= lowest(unmasked);
      first_error_valid <= 1'b1;
    end else if (wr_status && reg_req.wdata[first_error_ptr]) begin
      first_error_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      header_log_en    <= 1'b0;
      err_msg_fatal    <= 1'b0;
      err_msg_nonfatal <= 1'b0;
    end else begin
      header_log_en    <= |unmasked;
      err_msg_fatal    <= unm_fatal && !root_mode_s;
      err_msg_nonfatal <= unm_nonfatal && !root_mode_s;
    end
  end

  // ==========================================
  // System error interrupt
  logic fatal_ev;
  logic nonfatal_ev;
  logic cor_ev;
  assign fatal_ev    = link_msg.msg_fatal || unm_fatal;
  assign nonfatal_ev = link_msg.msg_nonfatal || unm_nonfatal;
  assign cor_ev      = link_msg.msg_cor || cor_detected;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      system_error_interrupt <= 1'b0;
    end else begin
      system_error_interrupt <= root_mode_s &&
        ((fatal_ev && root_control_reg[root_err_pkg::RC_FAT_EN]) ||
         (nonfatal_ev && root_control_reg[root_err_pkg::RC_NFAT_EN]) ||
         (cor_ev && root_control_reg[root_err_pkg::RC_COR_EN]));
    end
  end

  // ==========================================
  // PME status and interrupt
  logic pme_ie_prev;
  logic pme_ie;
  assign pme_ie = root_control_reg[root_err_pkg::RC_PME_IE];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pme_status  <= 1'b0;
      pme_ie_prev <= 1'b0;
    end else begin
      pme_ie_prev <= pme_ie;
      if (link_msg.pme_msg) begin
        pme_status <= 1'b1;
      end else if (hit(root_err_pkg::OFF_ROOT_CONTROL) && reg_req.wdata[16]) begin
        pme_status <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pme_interrupt <= 1'b0;
    end else begin
      pme_interrupt <= pme_ie && ((link_msg.pme_msg && !pme_status) ||
                                  (!pme_ie_prev && pme_status));
    end
  end

  // ==========================================
  // Register reads
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      unique case (reg_req.addr)
        root_err_pkg::OFF_ROOT_CONTROL: reg_rdata <= {15'h0000, pme_status, root_control_reg};
        root_err_pkg::OFF_UNC_STATUS:   reg_rdata <= uncorr_error_status_reg;
        root_err_pkg::OFF_UNC_MASK:     reg_rdata <= uncorr_error_mask_reg;
        root_err_pkg::OFF_UNC_SEVERITY: reg_rdata <= uncorr_error_severity_reg;
        root_err_pkg::OFF_SLOT_CONTROL: reg_rdata <= {slot_status_reg, slot_control_reg};
        default:                        reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule : pcie_root_error_control

// File: core/sticky_w1c_bank.sv
`timescale 1ns/1ps
module sticky_w1c_bank #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             por,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] q
);
  // ==========================================
  // Sticky set / write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (por) begin
      q <= '0;
    end else begin
      q <= (q & ~(wr_en ? wr_data : '0)) | set_bits;
    end
  end
endmodule : sticky_w1c_bank

// File: shared/root_err_pkg.sv
package root_err_pkg;
  // ==========================================
  // Register offsets
  localparam logic [11:0] OFF_UNC_STATUS   = 12'h104;
  localparam logic [11:0] OFF_UNC_MASK     = 12'h108;
  localparam logic [11:0] OFF_UNC_SEVERITY = 12'h10C;
  localparam logic [11:0] OFF_ROOT_CONTROL = 12'h0F4;
  localparam logic [11:0] OFF_SLOT_CONTROL = 12'h0EC;
  localparam logic [11:0] OFF_SLOT_STATUS  = 12'h0EE;

  // ==========================================
  // Root control fields
  localparam int RC_COR_EN   = 0;
  localparam int RC_NFAT_EN  = 1;
  localparam int RC_FAT_EN   = 2;
  localparam int RC_PME_IE   = 3;
  localparam logic [15:0] RC_WRITABLE = 16'h000F;
  localparam logic [15:0] RC_RESET    = 16'h0000;

  // ==========================================
  // Uncorrectable mask fields
  localparam int UM_TRAINING  = 0;
  localparam int UM_DLP       = 4;
  localparam int UM_POISONED  = 12;
  localparam int UM_FC_PROTO  = 13;
  localparam int UM_CPL_TO    = 14;
  localparam int UM_CPL_ABORT = 15;
  localparam int UM_UNEXP_CPL = 16;
  localparam int UM_RX_OVF    = 17;
  localparam int UM_MALFORMED = 18;
  localparam int UM_ECRC      = 19;
  localparam int UM_UNSUP_REQ = 20;
  localparam logic [31:0] UNC_DEFINED = 32'h001FF011;
  localparam logic [31:0] UNC_RESET   = 32'h00000000;
  localparam logic [15:0] SLOT_RESET  = 16'h0000;

  // ==========================================
  // Register access carrier
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Error and PME message events from the link
  typedef struct packed {
    logic msg_cor;
    logic msg_nonfatal;
    logic msg_fatal;
    logic pme_msg;
  } link_msg_t;
endpackage : root_err_pkg

// File: tb/link_partner.sv
`timescale 1ns/1ps
// ====
// Link partner message source
module link_partner (
  input  wire logic               sys_clk,
  input  wire logic               send,
  input  wire logic [3:0]         kind,
  input  wire logic [1:0]         lag,
  output root_err_pkg::link_msg_t link_msg
);
  logic [3:0] held = 4'h0;
  logic [1:0] cnt = 2'h0;
  logic       busy = 1'b0;
  initial link_msg = '0;
  // One-cycle message pulse after lag cycles
  always @(posedge sys_clk) begin
    link_msg <= '0;
    if (send) begin
      held <= kind;
      cnt  <= lag;
      busy <= 1'b1;
    end else if (busy && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (busy) begin
      link_msg <= held;
      busy     <= 1'b0;
    end
  end
endmodule : link_partner

// File: tb/root_err_asserts.sv
`timescale 1ns/1ps
// ====
// Port checker
module root_err_checker (
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic                    root_mode,
  input wire root_err_pkg::reg_req_t  reg_req,
  input wire logic [31:0]             reg_rdata,
  input wire logic                    reg_rvalid,
  input wire root_err_pkg::link_msg_t link_msg,
  input wire logic                    cor_detected,
  input wire logic [31:0]             unc_detected,
  input wire logic                    system_error_interrupt,
  input wire logic                    pme_interrupt,
  input wire logic                    pme_status,
  input wire logic                    err_msg_fatal,
  input wire logic                    err_msg_nonfatal,
  input wire logic                    header_log_en,
  input wire logic [4:0]              first_error_ptr,
  input wire logic                    first_error_valid
);
  logic any_unc;
  logic any_err;
  assign any_unc = |unc_detected;
  assign any_err = any_unc | cor_detected | link_msg.msg_cor | link_msg.msg_nonfatal
    | link_msg.msg_fatal;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_read_answer: assert property (reg_rvalid == $past(reg_req.rd))
    else $error("read answer off");
  a_rc_reserved: assert property (
    reg_rvalid && $past(reg_req.addr) == root_err_pkg::OFF_ROOT_CONTROL
    |-> reg_rdata[15:4] == 12'h000) else $error("reserved bits set");
  a_ep_no_serr: assert property (
    !root_mode [*4] |=> !system_error_interrupt) else $error("serr in endpoint");
  a_root_no_msg: assert property (
    root_mode [*4] |=> !err_msg_fatal && !err_msg_nonfatal) else $error("msg in root");
  a_pme_status: assert property (pme_interrupt |-> pme_status) else $error("pme");
  a_hdr_cause: assert property (header_log_en |-> $past(any_unc)) else $error("log");
  a_msg_cause: assert property (
    err_msg_fatal || err_msg_nonfatal |-> $past(any_unc)) else $error("msg no error");
  a_serr_cause: assert property (
    system_error_interrupt |-> $past(any_err)) else $error("serr no cause");
  a_ptr_hold: assert property (
    first_error_valid && !reg_req.wr |=> first_error_valid && $stable(first_error_ptr))
    else $error("pointer moved");
  c_serr: cover property (system_error_interrupt);
  c_pme: cover property (pme_interrupt);
  c_log: cover property (header_log_en);
endmodule : root_err_checker

bind pcie_root_error_control root_err_checker chk (.sys_clk, .srst, .root_mode, .reg_req,
  .reg_rdata, .reg_rvalid, .link_msg, .cor_detected, .unc_detected, .system_error_interrupt,
  .pme_interrupt, .pme_status, .err_msg_fatal, .err_msg_nonfatal, .header_log_en,
  .first_error_ptr, .first_error_valid);

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
// ====
// Bench top
module testbench;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        por = 1'b1;
  logic        root_mode = 1'b0;
  logic        cor_detected = 1'b0;
  logic        send = 1'b0;
  logic [3:0]  kind = 4'h0;
  logic [1:0]  lag = 2'h0;
  logic [31:0] unc_detected = 32'h0;
  logic [31:0] reg_rdata, mask, sev, status, sl;
  logic        reg_rvalid, serr, pme_irq, pme_status, msg_f, msg_nf, hdr, fe_valid;
  logic [4:0]  fe_ptr;
  int          miscompares = 0, checks_done = 0, serr_n = 0, pme_n = 0, b, k, m, n;
  int          fep = -1;
  root_err_pkg::reg_req_t  reg_req = '0;
  root_err_pkg::link_msg_t link_msg;
  pcie_root_error_control dut (.sys_clk, .srst, .por, .root_mode, .reg_req, .reg_rdata,
    .reg_rvalid, .link_msg, .cor_detected, .unc_detected, .system_error_interrupt(serr),
    .pme_interrupt(pme_irq), .pme_status, .err_msg_fatal(msg_f),
    .err_msg_nonfatal(msg_nf), .header_log_en(hdr), .first_error_ptr(fe_ptr),
    .first_error_valid(fe_valid));
  link_partner peer (.sys_clk, .send, .kind, .lag, .link_msg);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    serr_n <= serr_n + int'(serr === 1'b1);
    pme_n  <= pme_n + int'(pme_irq === 1'b1);
  end
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_req <= '{1'b1, 1'b0, a, d};
    tk(1);
    reg_req <= '0;
    tk(1);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    reg_req <= '{1'b0, 1'b1, a, 32'h0};
    tk(1);
    reg_req <= '0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("rdata", e, reg_rdata)
    tk(1);
  endtask : rdc
  task automatic unc(input int i);
    unc_detected <= 32'h1 << i;
    tk(1);
    unc_detected <= 32'h0;
    status[i] = 1'b1;
    if (fep < 0 && !mask[i]) fep = i;
    #1;
    `CHK("hdr", !mask[i], hdr)
    `CHK("fatal", !mask[i] && sev[i], msg_f)
    `CHK("nonfatal", !mask[i] && !sev[i], msg_nf)
    `CHK("fe_valid", fep >= 0, fe_valid)
    if (fep >= 0) `CHK("fe_ptr", 5'(fep), fe_ptr)
    tk(1);
  endtask : unc
  task automatic msg(input logic [3:0] c);
    int i;
    kind <= c;
    lag  <= 2'($urandom);
    send <= 1'b1;
    tk(1);
    send <= 1'b0;
    for (i = 0; i < 8 && link_msg === 4'h0; i++) tk(1);
    if (link_msg === 4'h0) begin
      miscompares++;
      end_of_test();
    end
    tk(3);
  endtask : msg
  task automatic det(input int c);
    if (c == 0) cor_detected <= 1'b1;
    else unc_detected <= (c == 1) ? 32'h1 : 32'h10;
    tk(1);
    cor_detected <= 1'b0;
    unc_detected <= 32'h0;
    tk(3);
  endtask : det
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(25484));
    status = 32'h0;
    tk(8);
    srst <= 1'b0;
    por  <= 1'b0;
    tk(3);
    rdc(root_err_pkg::OFF_ROOT_CONTROL, 32'h0);
    rdc(root_err_pkg::OFF_UNC_MASK, 32'h0);
    wr(root_err_pkg::OFF_ROOT_CONTROL, 32'h0000FFFF);
    rdc(root_err_pkg::OFF_ROOT_CONTROL, 32'h0000000F);
    sl = $urandom;
    wr(root_err_pkg::OFF_SLOT_CONTROL, sl);
    rdc(root_err_pkg::OFF_SLOT_CONTROL, sl);
    rdc(12'hFFC, 32'h0);
    mask = $urandom;
    sev  = $urandom;
    wr(root_err_pkg::OFF_UNC_MASK, mask);
    wr(root_err_pkg::OFF_UNC_SEVERITY, sev);
    rdc(root_err_pkg::OFF_UNC_MASK, mask);
    rdc(root_err_pkg::OFF_UNC_SEVERITY, sev);
    for (b = 0; b < 21; b++) if (root_err_pkg::UNC_DEFINED[b]) begin
      unc(b);
      wr(root_err_pkg::OFF_UNC_STATUS, 32'h0);
      if ($urandom_range(1) == 1) begin
        wr(root_err_pkg::OFF_UNC_STATUS, 32'h1 << b);
        status[b] = 1'b0;
        if (fep == b) fep = -1;
      end
      rdc(root_err_pkg::OFF_UNC_STATUS, status);
    end
    `CHK("serr_ep", 0, serr_n)
    srst <= 1'b1;
    tk(8);
    srst <= 1'b0;
    tk(3);
    rdc(root_err_pkg::OFF_UNC_STATUS, status);
    rdc(root_err_pkg::OFF_UNC_MASK, mask);
    rdc(root_err_pkg::OFF_ROOT_CONTROL, 32'h0);
    `CHK("fe_keep", fep >= 0, fe_valid)
    wr(root_err_pkg::OFF_UNC_MASK, 32'h0);
    wr(root_err_pkg::OFF_UNC_SEVERITY, 32'h10);
    for (m = 0; m < 2; m++) begin
      root_mode <= m[0];
      tk(4);
      for (k = 0; k < 6; k++) begin
        wr(root_err_pkg::OFF_ROOT_CONTROL, 32'(k % 2) << (k / 2));
        n = serr_n;
        msg(4'h8 >> (k / 2));
        det(k / 2);
        `CHK("serr", 2 * (m & k & 1), serr_n - n)
      end
    end
    n = pme_n;
    wr(root_err_pkg::OFF_ROOT_CONTROL, 32'h8);
    msg(4'h1);
    `CHK("pme_status", 1'b1, pme_status)
    wr(root_err_pkg::OFF_ROOT_CONTROL, 32'h10000);
    msg(4'h1);
    wr(root_err_pkg::OFF_ROOT_CONTROL, 32'h8);
    tk(3);
    `CHK("pme_irq", n + 2, pme_n)
    end_of_test();
  end
endmodule : testbench
